// >>> inc/smp_defs.vh
`ifndef SMP_DEFS_VH
`define SMP_DEFS_VH
// Command frame bytes.
`define SMP_PREFIX_HOST 8'hd4
`define SMP_PREFIX_RESP 8'hd5
`define SMP_CODE_CFG 8'h14
`define SMP_CODE_RESP 8'h15
// Mode encodings.
`define SMP_MODE_NORMAL 8'h01
`define SMP_MODE_VIRTUAL 8'h02
`define SMP_MODE_WIRED 8'h03
`define SMP_MODE_DUAL 8'h04
// Interrupt-use byte values.
`define SMP_IRQ_OFF 8'h00
`define SMP_IRQ_ON 8'h01
// Status bytes in the response.
`define SMP_STAT_OK 8'h00
`define SMP_STAT_SYNTAX 8'h27
// Timeout unit in milliseconds.
`define SMP_TICK_MS 50
// Register offsets.
`define SMP_REG_CMD 4'h0
`define SMP_REG_CFG 4'h1
`define SMP_REG_STAT 4'h2
`define SMP_REG_RESP 4'h3
// Cause bit positions in the status register.
`define SMP_CAUSE_PULSE 0
`define SMP_CAUSE_RFOFF 1
`define SMP_CAUSE_TOUT 2
`endif

// >>> core/smp_monitor.v
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "smp_defs.vh"
module smp_monitor #(
  parameter CLK_KHZ = 25000,
  parameter TICK_CYCLES = `SMP_TICK_MS * CLK_KHZ
) (
  input wire ref_clk_i, // 25 MHz clock.
  input wire rst_b_i, // Asynchronous reset, active low.
  input wire [3:0] addr_i, // Register address.
  input wire [7:0] wdata_i, // Write data.
  input wire wr_i, // Write strobe.
  input wire rd_i, // Read strobe.
  output reg [7:0] rdata_o, // Read data, one cycle after the strobe.
  input wire module_activity_irq_i, // Byte sent by the module, from pin.
  input wire module_transaction_active_n_i, // Transaction line, low active.
  input wire rf_field_i, // External field present.
  input wire rate_106a_i, // Link runs 106 kbps type A.
  output reg module_path_en_o, // Serial switch routes to the module.
  output reg wired_reader_o, // Reader toward the module internally.
  output reg rf_emit_allow_o, // Own field may be emitted.
  output reg ext_reader_allow_o, // React to an external reader.
  output reg dual_target_o, // Present both targets.
  output reg low_power_o, // Low power until a field appears.
  output reg host_alert_pin_o, // Alert pin level, low active.
  output reg host_alert_pin_oe_o // Alert pin driven.
);

  // Reset release through two flops. The reset is taken at once, but its
  // release is moved onto the clock so that no register leaves reset on a
  // different edge from its neighbours. Everything below uses rst_n.
  // The cost is two cycles after release in which the block still rests.
  reg rst_s1;
  reg rst_n;
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Pin inputs pass two flops before any logic sees them.
  // Bit 0 is module activity, bit 1 the transaction line and bit 2 the field.
  // A third flop holds the previous synchronised level for edge detection.
  // The reset value matches the idle level of each pin: no activity, the
  // transaction line high on its pull-up and no field. A different value
  // would show a false edge right after reset.
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [2:0] pin_d;
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 3'h2;
      pin_s2 <= 3'h2;
      pin_d <= 3'h2;
    end else begin
      pin_s1 <= {rf_field_i, module_transaction_active_n_i, module_activity_irq_i};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  // Edge and level views of the synchronised pins. Only the second flop and
  // the edge flop are read here; the first flop feeds nothing but the second.
  wire act_rise = pin_s2[0] & ~pin_d[0];
  wire line_rise = pin_s2[1] & ~pin_d[1];
  wire line_fall = ~pin_s2[1] & pin_d[1];
  wire rf_on = pin_s2[2];
  wire rf_fall = ~pin_s2[2] & pin_d[2];

  // The rate strap is a level from outside this block, so it is synchronised
  // like the pins. It is read only when a frame ends, several bus cycles after
  // any change that the host would make to it. Until it has passed the flops,
  // card modes are refused.
  reg rate_s1;
  reg rate_s2;
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rate_s1 <= 1'b0;
      rate_s2 <= 1'b0;
    end else begin
      rate_s1 <= rate_106a_i;
      rate_s2 <= rate_s1;
    end
  end

  // Mode check, used by the frame parser only; the switch decode compares the mode directly.
  // The four legal codes are contiguous, so a range test is enough.
  // Any other code refuses the whole frame and the old mode stays.
  function mode_ok;
    input [7:0] m;
    begin
      mode_ok = (m >= `SMP_MODE_NORMAL) && (m <= `SMP_MODE_DUAL);
    end
  endfunction

  // Frame parser states. The parser walks the bytes of one command frame
  // as they are written into the command register, one byte per write.
  // Idle waits for the host prefix, then the command code is checked.
  // A wrong code drops back to idle and the rest of the frame is ignored.
  // The mode, timeout and interrupt-use bytes follow in that order; the last
  // state soaks up any extra bytes, each of which overwrites the interrupt-use byte.
  // The frame is closed by a write to the config register, whatever the data.
  localparam ST_IDLE = 5'h01;
  localparam ST_CODE = 5'h02;
  localparam ST_MODE = 5'h04;
  localparam ST_TOUT = 5'h08;
  localparam ST_IRQB = 5'h10;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [7:0] mode;
  reg [7:0] tout;
  reg irq_use;
  reg [7:0] p_mode;
  reg [7:0] p_tout;
  reg p_tout_seen;
  reg p_irq;
  reg [7:0] resp_code;
  reg [7:0] resp_stat;
  reg resp_valid;
  reg [2:0] cause;
  reg txn_seen;
  reg line_low;
  reg [7:0] tout_cnt;
  reg [31:0] tick_cnt;
  reg virt_entry;

  wire cmd_wr = wr_i && (addr_i == `SMP_REG_CMD);
  // A write to the config register ends the frame; its data are not looked at.
  wire frame_end = wr_i && (addr_i == `SMP_REG_CFG);
  // A frame ending before the mode byte, or virtual without timeout, is a syntax error.
  wire bad_frame = (state == ST_IDLE) || (state == ST_CODE) || (state == ST_MODE) ||
    !mode_ok(p_mode) || (p_mode == `SMP_MODE_VIRTUAL && !p_tout_seen) ||
    (p_mode != `SMP_MODE_NORMAL && !rate_s2);

  // Next parser state from the byte stream.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (cmd_wr && wdata_i == `SMP_PREFIX_HOST) next_state = ST_CODE;
      ST_CODE: if (cmd_wr) next_state = (wdata_i == `SMP_CODE_CFG) ? ST_MODE : ST_IDLE;
      ST_MODE: if (cmd_wr) next_state = ST_TOUT;
      ST_TOUT: if (cmd_wr) next_state = ST_IRQB;
      ST_IRQB: next_state = ST_IRQB;
      default: next_state = ST_IDLE;
    endcase
    if (frame_end) next_state = ST_IDLE;
  end

  // Byte capture, validation and mode apply.
  // Bytes are held in pending copies until the frame closes. Only a frame
  // that passes every check copies them into the applied mode, timeout and
  // interrupt-use settings, so a refused frame leaves the block as it was.
  // A new prefix forgets the timeout and interrupt-use bytes of the last
  // frame, so that an absent byte falls back to its default.
  // The response status stays pending until the host reads it once.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      mode <= `SMP_MODE_NORMAL;
      tout <= 8'h00;
      irq_use <= 1'b1;
      p_mode <= 8'h00;
      p_tout <= 8'h00;
      p_tout_seen <= 1'b0;
      p_irq <= 1'b1;
      resp_code <= 8'h00;
      resp_stat <= 8'h00;
      resp_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (cmd_wr && state == ST_MODE) p_mode <= wdata_i;
      if (cmd_wr && state == ST_TOUT) begin
        p_tout <= wdata_i;
        p_tout_seen <= 1'b1;
      end
      if (cmd_wr && state == ST_IRQB) p_irq <= (wdata_i != `SMP_IRQ_OFF);
      if (cmd_wr && state == ST_IDLE) begin
        p_tout_seen <= 1'b0;
        p_irq <= 1'b1;
      end
      if (rd_i && addr_i == `SMP_REG_RESP) resp_valid <= 1'b0;
      if (frame_end) begin
        resp_code <= `SMP_CODE_RESP;
        resp_valid <= 1'b1;
        if (bad_frame) begin
          resp_stat <= `SMP_STAT_SYNTAX;
        end else begin
          resp_stat <= `SMP_STAT_OK;
          mode <= p_mode;
          // Timeout matters only in virtual mode.
          tout <= (p_mode == `SMP_MODE_VIRTUAL) ? p_tout : 8'h00;
          irq_use <= p_irq;
        end
      end
    end
  end

  wire virt = (mode == `SMP_MODE_VIRTUAL);
  wire applied_virt = frame_end && !bad_frame && p_mode == `SMP_MODE_VIRTUAL;

  // Switch decode from the applied mode.
  // Each role output is a registered level, so the switch moves one cycle
  // after the mode is applied and never glitches while the mode settles.
  // Wired mode turns the own field and the external reader off together.
  // Dual mode keeps the external reader, since both targets answer it.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      module_path_en_o <= 1'b0;
      wired_reader_o <= 1'b0;
      rf_emit_allow_o <= 1'b1;
      ext_reader_allow_o <= 1'b1;
      dual_target_o <= 1'b0;
    end else begin
      module_path_en_o <= mode != `SMP_MODE_NORMAL;
      wired_reader_o <= mode == `SMP_MODE_WIRED;
      rf_emit_allow_o <= mode == `SMP_MODE_NORMAL;
      ext_reader_allow_o <= mode != `SMP_MODE_WIRED;
      dual_target_o <= mode == `SMP_MODE_DUAL;
    end
  end

  // Transaction supervision in virtual mode. An event beats a status clear.
  // Three detectors can close a transaction: a full low pulse on the
  // transaction line with the field present, loss of the field after some
  // module activity, and the timeout after the last activity. Each sets its
  // own cause bit, which stays until the host reads the status register.
  // The timeout is a step counter of TICK_CYCLES clocks beside a step
  // down-counter; the step counter restarts on activity, so the timeout runs
  // from the last activity edge to within one clock.
  // Entry into virtual mode is delayed one cycle so that low power rises
  // together with the role outputs and never ahead of them.
  wire tick = (tick_cnt == TICK_CYCLES - 1);
  wire ev_pulse = virt && line_rise && line_low && rf_on;
  wire ev_rfoff = virt && rf_fall && txn_seen;
  wire ev_tout = virt && tout != 8'h00 && txn_seen && !act_rise && tick &&
    tout_cnt == 8'h01;
  wire stat_clr = rd_i && addr_i == `SMP_REG_STAT;
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      txn_seen <= 1'b0;
      line_low <= 1'b0;
      tout_cnt <= 8'h00;
      tick_cnt <= 32'h0;
      cause <= 3'h0;
      virt_entry <= 1'b0;
      low_power_o <= 1'b0;
    end else begin
      virt_entry <= applied_virt;
      tick_cnt <= (tick || act_rise) ? 32'h0 : tick_cnt + 32'h1;
      if (!virt) begin
        txn_seen <= 1'b0;
        line_low <= 1'b0;
      end else begin
        // The edge detector acts as the cleared activity flag.
        if (act_rise) txn_seen <= 1'b1;
        if (line_fall) line_low <= 1'b1;
        else if (line_rise) line_low <= 1'b0;
        if (ev_pulse || ev_rfoff || ev_tout) txn_seen <= 1'b0;
      end
      if (act_rise) tout_cnt <= tout;
      else if (tick && tout_cnt != 8'h00) tout_cnt <= tout_cnt - 8'h01;
      cause <= (stat_clr ? 3'h0 : cause) | {ev_tout, ev_rfoff, ev_pulse};
      // Low power waits for a field; it is left at once when one is seen.
      if (virt_entry) low_power_o <= 1'b1;
      else if (rf_on || !virt) low_power_o <= 1'b0;
    end
  end

  // Alert pin: low while a cause is pending, released high when unused.
  // The pin is always driven; when alerts are switched off it is driven high
  // rather than left floating, so the host never sees a false alert.
  // The alert clears when the host reads the status and no new cause arrives.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_alert_pin_o <= 1'b1;
      host_alert_pin_oe_o <= 1'b1;
    end else begin
      host_alert_pin_o <= !(irq_use && cause != 3'h0);
      host_alert_pin_oe_o <= 1'b1;
    end
  end

  // Register read port.
  // Read data stand for one cycle after the strobe and are zero otherwise,
  // so a stale value can never be taken for a fresh answer.
  // Reading the response register when nothing is pending gives all ones.
  // Unmapped addresses read as zero.
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SMP_REG_CFG: rdata_o <= mode;
        `SMP_REG_STAT: rdata_o <= {txn_seen, 4'h0, cause};
        `SMP_REG_RESP: rdata_o <= resp_valid ? resp_stat : 8'hff;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // smp_monitor

// >>> tb/smp_monitor_props.sv
`timescale 1ns/1ps
// Ties the mode outputs and the alert pin to bus writes and to the pins.
module smp_monitor_props (
  input wire ref_clk_i, // Clock.
  input wire rst_b_i, // Reset, low active.
  input wire wr_i, // Write strobe.
  input wire module_transaction_active_n_i, // Transaction line.
  input wire rf_field_i, // Field present.
  input wire module_path_en_o, // Path to module.
  input wire wired_reader_o, // Wired reader.
  input wire rf_emit_allow_o, // Own field allowed.
  input wire ext_reader_allow_o, // External reader allowed.
  input wire dual_target_o, // Two targets.
  input wire low_power_o, // Low power.
  input wire host_alert_pin_o, // Alert pin.
  input wire host_alert_pin_oe_o // Alert pin enable.
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Role bits; low power is kept apart because it also follows the field.
  wire [2:0] role = {module_path_en_o, wired_reader_o, dual_target_o};
  wire virt = role == 3'b100;
  a_pin_enabled: assert property (host_alert_pin_oe_o)
    else $error("alert pin released");
  a_wired_quiet: assert property (wired_reader_o |-> !rf_emit_allow_o && !ext_reader_allow_o)
    else $error("wired mode not quiet");
  a_normal_idle: assert property (!module_path_en_o |-> role == 3'b000 && !low_power_o)
    else $error("normal mode routes");
  a_dual_reader: assert property (dual_target_o |-> ext_reader_allow_o)
    else $error("dual mode hides reader");
  // A role may only move two or three cycles after a bus write.
  a_mode_written: assert property (!$stable(role) |-> $past(wr_i, 2) || $past(wr_i, 3))
    else $error("mode moved without a frame");
  a_sleep_virtual: assert property ($rose(low_power_o) |-> virt)
    else $error("sleep outside virtual mode");
  a_field_wakes: assert property (low_power_o && rf_field_i |-> ##[1:8] !low_power_o)
    else $error("no wake on field");
  a_pulse_alert: assert property ($rose(module_transaction_active_n_i) && rf_field_i && virt
    |-> ##[1:8] !host_alert_pin_o) else $error("line pulse not alerted");
  c_dual: cover property ($rose(dual_target_o));
  c_alert: cover property ($fell(host_alert_pin_o));
  c_wake: cover property ($fell(low_power_o));
endmodule // smp_monitor_props

// >>> tb/smp_far_model.sv
`timescale 1ns/1ps
// Far-side module: a burst of three bytes, framed by the line when it is used.
module smp_far_model (
  input wire ref_clk_i, // Clock.
  input wire start_i, // Begin a burst.
  input wire use_line_i, // Module drives the transaction line.
  input wire [3:0] gap_i, // Slowness: idle cycles between bytes, less two.
  output reg activity_o, // One pulse per byte.
  output reg txn_n_o, // Transaction line, low active.
  output reg busy_o // Burst under way.
);
  // An unused line rests on its pull-up, so it stays high.
  initial {activity_o, txn_n_o, busy_o} = 3'b010;
  // The line falls on the request and rises only after the last byte.
  always @(posedge ref_clk_i) begin
    if (start_i && !busy_o) begin
      {busy_o, txn_n_o} <= {1'b1, !use_line_i};
      repeat (3) begin
        repeat (gap_i + 2) @(posedge ref_clk_i);
        activity_o <= 1'b1;
        @(posedge ref_clk_i);
        activity_o <= 1'b0;
      end
      repeat (4) @(posedge ref_clk_i);
      {busy_o, txn_n_o} <= 2'b01;
    end
  end
endmodule // smp_far_model

// >>> tb/smp_monitor_tb.sv
`timescale 1ns/1ps
module smp_monitor_tb;
  reg ref_clk_i, rst_b_i, wr_i, rd_i, rf, rate, go, ln;
  reg [3:0] addr_i, gap;
  reg [7:0] wdata_i, v;
  wire [7:0] rdata_o;
  wire module_activity_irq_i, module_transaction_active_n_i, module_path_en_o, busy;
  wire wired_reader_o, rf_emit_allow_o, ext_reader_allow_o, dual_target_o, low_power_o;
  wire host_alert_pin_o, host_alert_pin_oe_o;
  int miscompares = 0, total_checks = 0, exp_mode = 1, t, md[4] = '{2, 1, 3, 4};
  // A ten-cycle timeout unit keeps supervision short.
  smp_monitor #(.TICK_CYCLES(10)) i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .module_activity_irq_i(module_activity_irq_i),
    .module_transaction_active_n_i(module_transaction_active_n_i), .rf_field_i(rf),
    .rate_106a_i(rate), .module_path_en_o(module_path_en_o),
    .wired_reader_o(wired_reader_o), .rf_emit_allow_o(rf_emit_allow_o),
    .ext_reader_allow_o(ext_reader_allow_o), .dual_target_o(dual_target_o),
    .low_power_o(low_power_o), .host_alert_pin_o(host_alert_pin_o),
    .host_alert_pin_oe_o(host_alert_pin_oe_o));
  smp_far_model i_far (.ref_clk_i(ref_clk_i), .start_i(go), .use_line_i(ln), .gap_i(gap),
    .activity_o(module_activity_irq_i), .txn_n_o(module_transaction_active_n_i),
    .busy_o(busy));
  // Clock of 40 ns.
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A write strobe is held past its edge until the next task call drives the bus.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    {addr_i, wdata_i, wr_i, rd_i} <= {a, d, 2'b10};
    cyc(1);
  endtask
  task automatic rd(input logic [3:0] a);
    {addr_i, wr_i, rd_i} <= {a, 2'b01};
    cyc(1);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Reference decoder; a refused frame keeps the old mode.
  task automatic cfg(input int q[$]);
    int e;
    e = (q.size() < 3 || q[2] < 1 || q[2] > 4 || (q[2] != 1 && !rate)
      || (q[2] == 2 && q.size() < 4)) ? 8'h27 : 8'h00;
    if (e == 0) exp_mode = q[2];
    foreach (q[i]) wr(4'h0, q[i][7:0]);
    wr(4'h1, 8'h00);
    rd(4'h3);
    chk("status", v, 8'(e));
    rd(4'h1);
    chk("mode", v, 8'(exp_mode));
    chk("roles", {2'h0, rf_emit_allow_o, ext_reader_allow_o, dual_target_o, wired_reader_o,
      module_path_en_o, low_power_o}, {2'h0, exp_mode == 1, exp_mode != 3, exp_mode == 4,
      exp_mode == 3, exp_mode != 1, exp_mode == 2 && !rf});
  endtask
  // Normal first, so that no card mode is entered straight from another one.
  task automatic vc(input int q[$]);
    cfg('{8'hd4, 8'h14, 1, 0});
    rf <= 1'b0;
    cfg(q);
  endtask
  task automatic cause(input logic [7:0] e);
    rd(4'h2);
    chk("cause", v & 8'h07, e);
  endtask
  task automatic burst(input logic use_line);
    {go, ln} <= {1'b1, use_line};
    cyc(1);
    go <= 1'b0;
    #1;
    repeat (200) if (busy) cyc(1);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well past the length of the sequence.
  initial begin
    cyc(5000);
    miscompares++;
    finish_test;
  end
  // Reset, every mode, refused frames, then each end-of-transaction source.
  initial begin
    {rst_b_i, wr_i, rd_i, rf, go, ln, addr_i, wdata_i, gap} = 'h0;
    rate = 1'b1;
    void'($urandom(32'h201d1b35));
    cyc(12);
    rst_b_i <= 1'b1;
    cyc(3);
    chk("reset", {dual_target_o, wired_reader_o, module_path_en_o, rf_emit_allow_o,
      ext_reader_allow_o, low_power_o, host_alert_pin_o, host_alert_pin_oe_o}, 8'h1b);
    foreach (md[i]) cfg('{8'hd4, 8'h14, md[i], 0});
    cfg('{8'hd4, 8'h14, 5, 0});
    cfg('{8'hd4, 8'h14});
    cfg('{8'hd4, 8'h14, 2});
    rate <= 1'b0;
    cyc(1);
    cfg('{8'hd4, 8'h14, 3, 0});
    rate <= 1'b1;
    t = $urandom_range(4, 2);
    gap <= 4'($urandom_range(15, 0));
    vc('{8'hd4, 8'h14, 2, t, 0});
    rf <= 1'b1;
    burst(1'b0);
    cyc((t - 1) * 10 - 8);
    cause(8'h00);
    cyc(30);
    cause(8'h04);
    chk("pin", {6'h0, host_alert_pin_o, low_power_o}, 8'h02);
    vc('{8'hd4, 8'h14, 2, 0});
    rf <= 1'b1;
    cyc(10);
    burst(1'b1);
    cyc(40);
    chk("pin", {7'h0, host_alert_pin_o}, 8'h00);
    cause(8'h01);
    vc('{8'hd4, 8'h14, 2, 0});
    rf <= 1'b1;
    cyc(10);
    rf <= 1'b0;
    cyc(10);
    cause(8'h00);
    rf <= 1'b1;
    burst(1'b0);
    rf <= 1'b0;
    cyc(10);
    cause(8'h02);
    finish_test;
  end
endmodule // smp_monitor_tb
bind smp_monitor smp_monitor_props i_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .wr_i(wr_i), .module_transaction_active_n_i(module_transaction_active_n_i),
  .rf_field_i(rf_field_i), .module_path_en_o(module_path_en_o),
  .wired_reader_o(wired_reader_o), .rf_emit_allow_o(rf_emit_allow_o),
  .ext_reader_allow_o(ext_reader_allow_o), .dual_target_o(dual_target_o),
  .low_power_o(low_power_o), .host_alert_pin_o(host_alert_pin_o),
  .host_alert_pin_oe_o(host_alert_pin_oe_o));
